// [shared/arml_defines.svh]
`ifndef ARML_DEFINES_SVH
`define ARML_DEFINES_SVH

// System clock rate, in hertz and in megahertz.
`define ARML_SYS_CLK_HZ     27'h5F5E100
`define ARML_SYS_CLK_MHZ    100
// Lowest and highest programmable sample rates, in hertz.
`define ARML_RATE_MIN       16'h1B58
`define ARML_RATE_MAX       16'hBB80
// Rate used whenever the codec link carries the mix, in hertz.
`define ARML_LINK_RATE      16'hBB80
// Least low time of the link reset, in nanoseconds (1.0 us).
`define ARML_RST_LOW_NS     1000
// Same time in system clocks, rounded up.
`define ARML_RST_LOW_CYC \
    (((`ARML_RST_LOW_NS * `ARML_SYS_CLK_MHZ) + 999) / 1000)
// Last bit index of a 256-bit frame.
`define ARML_FRAME_LAST     8'hFF
// Sync high length in bit clocks (about 1.3 us at 81.4 ns a bit).
`define ARML_SYNC_BITS      8'h10
// Tag slot bit positions: frame valid, slot 3 and slot 4 valid.
`define ARML_TAG_FV_POS     8'h00
`define ARML_TAG_S3_POS     8'h03
`define ARML_TAG_S4_POS     8'h04
// First bit of the left and right PCM slots.
`define ARML_SLOT3_START    8'h38
`define ARML_SLOT4_START    8'h4C
// Number of sample bits sent at the head of a 20-bit slot.
`define ARML_SLOT_DATA_BITS 8'h10

`endif

// [shared/arml_pkg.sv]
package arml_pkg;
    // Link control states, Gray coded along off, reset, run.
    typedef enum logic [1:0] {
        LNK_OFF   = 2'b00,
        LNK_RESET = 2'b01,
        LNK_RUN   = 2'b11
    } arml_link_state_type;
endpackage

// [logic/arml_fifo.sv]
`include "arml_defines.svh"

////////////////////////////////////////////////////////////////////////////
// Flip-flop FIFO with valid and ready on both sides.
module arml_fifo
    import arml_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16
)(
    input  wire logic             sys_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             wr_valid_in,
    output logic                  wr_ready_out,
    input  wire logic [WIDTH-1:0] wr_data_in,
    output logic                  rd_valid_out,
    input  wire logic             rd_ready_in,
    output logic      [WIDTH-1:0] rd_data_out
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];   // Storage words.
    logic [WIDTH-1:0] mem_d [DEPTH];   // Next storage words.
    logic [AW:0]      wp_q, wp_d;      // Write pointer with wrap bit.
    logic [AW:0]      rp_q, rp_d;      // Read pointer with wrap bit.
    logic             full, empty;     // Honest occupancy flags.
    logic             push, pop;       // Handshakes taken this cycle.

    // Full when pointers differ only in the wrap bit.
    assign empty        = (wp_q == rp_q);
    assign full         = (wp_q[AW-1:0] == rp_q[AW-1:0]) &&
                          (wp_q[AW] != rp_q[AW]);
    assign wr_ready_out = !full;
    assign rd_valid_out = !empty;
    assign rd_data_out  = mem_q[rp_q[AW-1:0]];
    assign push         = wr_valid_in && !full;
    assign pop          = rd_ready_in && !empty;

    // Next pointers and storage.
    always_comb
    begin
        wp_d  = push ? wp_q + 1'b1 : wp_q;
        rp_d  = pop ? rp_q + 1'b1 : rp_q;
        mem_d = mem_q;
        if (push)
        begin
            mem_d[wp_q[AW-1:0]] = wr_data_in;
        end
    end

    // Registers only; storage needs no reset since empty hides it.
    always_ff @(posedge sys_clk_in)
    begin
        mem_q <= mem_d;
        if (!rst_n_in)
        begin
            wp_q <= '0;
            rp_q <= '0;
        end
        else
        begin
            wp_q <= wp_d;
            rp_q <= rp_d;
        end
    end
endmodule // arml_fifo

// [logic/arml_audio_link.sv]
// Functional notes
// - Two host streams resampled, then mixed together.
// - Stream rates 7 to 48 kHz, 1 Hz steps.
// - Mono or stereo, 16-bit signed or 8-bit unsigned.
// - Music summed into wave stream before link.
// - Mix goes to host or codec link.
// - Link output always resampled to 48 kHz.
// - Link off: output rate programmable 7-48 kHz.
// - Cold reset holds link reset low 1 us.
// - Sync high 1.3 us, low 19.5 us.
`include "arml_defines.svh"

////////////////////////////////////////////////////////////////////////////
// Resample, mix and route audio; format frames for the codec link.
module arml_audio_link
    import arml_pkg::*;
#(
    parameter int FIFO_DEPTH = 16
)(
    input  wire logic             sys_clk_in,
    input  wire logic             rst_n_in,
    input  wire logic [1:0]       strm_valid_in,
    output logic      [1:0]       strm_ready_out,
    input  wire logic [1:0][31:0] strm_data_in,
    input  wire logic [1:0][15:0] strm_rate_in,
    input  wire logic [1:0]       strm_fmt16_in,
    input  wire logic [1:0]       strm_stereo_in,
    input  wire logic             music_valid_in,
    output logic                  music_ready_out,
    input  wire logic [31:0]      music_data_in,
    input  wire logic [15:0]      host_rate_in,
    output logic                  host_valid_out,
    input  wire logic             host_ready_in,
    output logic      [31:0]      host_data_out,
    input  wire logic             link_enable_in,
    input  wire logic             link_cold_reset_in,
    input  wire logic             bit_clk_in,
    output logic                  sync_out,
    output logic                  sdata_out,
    output logic                  codec_rst_n_out
);
    ////////////////////////////////////////////////////////////////////////
    // Declarations.
    arml_link_state_type st_q, st_d;   // Link control state.
    logic [7:0]  rcnt_q, rcnt_d;       // Link reset low counter.
    logic        crst_n_q, crst_n_d;   // Registered link reset level.
    logic        bclk_q;               // Previous bit clock sample.
    logic        brise;                // Bit clock rising edge.
    logic [7:0]  bit_q, bit_d;         // Bit index within the frame.
    logic [7:0]  bit_nx;               // Bit index being launched.
    logic        sync_q, sync_d;       // Registered sync level.
    logic        sdo_q, sdo_d;         // Registered serial data.
    logic [31:0] frm_q, frm_d;         // Sample pair of this frame.
    logic        fv_q, fv_d;           // Frame carries valid PCM.
    logic        link_on;              // Link in the run state.
    logic [15:0] out_rate;             // Effective output rate.
    logic [26:0] nco_q, nco_d;         // Output tick accumulator.
    logic        pend_q, pend_d;       // Output sample awaiting sink.
    logic        sink_rdy;             // Selected sink accepts.
    logic        fire;                 // Output sample taken.
    logic [31:0] mus_q, mus_d;         // Held music sample pair.
    logic [31:0] mix_q, mix_d;         // Registered mixed pair.
    logic [1:0][31:0] hold_q;          // Held converted stream pairs.
    logic [1:0][31:0] hold_d;
    logic [1:0][16:0] acc_q;           // Per-stream rate accumulators.
    logic [1:0][16:0] acc_d;
    logic [1:0][15:0] in_rate;         // Clamped stream rates.
    logic [1:0]  take;                 // Stream sample taken.
    logic        fifo_wr_rdy;          // FIFO can take a pair.
    logic        fifo_rd_vld;          // FIFO holds a pair.
    logic        fifo_pop;             // Pair loaded into a frame.
    logic [31:0] fifo_rd_data;         // Pair at the FIFO head.
    logic [15:0] rlow_q;               // Checking aid: reset low time.

    ////////////////////////////////////////////////////////////////////////
    // Helpers.

    // Keeps any programmed rate inside the supported range.
    function automatic logic [15:0] clamp_rate(input logic [15:0] r);
        if (r < `ARML_RATE_MIN) return `ARML_RATE_MIN;
        if (r > `ARML_RATE_MAX) return `ARML_RATE_MAX;
        return r;
    endfunction

    // Turns one stream word into a signed 16-bit left/right pair.
    function automatic logic [31:0] conv(input logic [31:0] w,
                                         input logic f16,
                                         input logic st);
        logic [15:0] l;
        logic [15:0] r;
        l = f16 ? w[15:0] : {w[7:0] ^ 8'h80, 8'h00};
        r = f16 ? w[31:16] : {w[15:8] ^ 8'h80, 8'h00};
        return {st ? r : l, l};
    endfunction

    // Saturating three-way signed sum; clipping beats wrap-around.
    function automatic logic [15:0] sat3(input logic [15:0] a,
                                         input logic [15:0] b,
                                         input logic [15:0] c);
        logic signed [17:0] s;
        s = 18'(signed'(a)) + 18'(signed'(b)) + 18'(signed'(c));
        if (s > 18'sh07FFF) return 16'h7FFF;
        if (s < -18'sh08000) return 16'h8000;
        return s[15:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Per-stream rate converters: a stream sample is taken whenever the
    // accumulated input rate reaches the output rate. Zero-order hold
    // keeps area tiny at the cost of image rejection.
    for (genvar i = 0; i < 2; i++)
    begin : g_src
        assign in_rate[i]        = clamp_rate(strm_rate_in[i]);
        assign take[i]           = strm_valid_in[i] &&
                                   (acc_q[i] >= {1'b0, out_rate});
        assign strm_ready_out[i] = (acc_q[i] >= {1'b0, out_rate});

        // Accumulator stops growing once a sample is owed, so a silent
        // host cannot overflow it.
        always_comb
        begin
            acc_d[i]  = acc_q[i];
            hold_d[i] = hold_q[i];
            if (take[i])
            begin
                acc_d[i]  = acc_d[i] - {1'b0, out_rate};
                hold_d[i] = conv(strm_data_in[i], strm_fmt16_in[i],
                                 strm_stereo_in[i]);
            end
            if (fire && !(acc_q[i] >= {1'b0, out_rate}))
            begin
                acc_d[i] = acc_d[i] + {1'b0, in_rate[i]};
            end
        end

        // Registers only.
        always_ff @(posedge sys_clk_in)
        begin
            if (!rst_n_in)
            begin
                acc_q[i]  <= '0;
                hold_q[i] <= '0;
            end
            else
            begin
                acc_q[i]  <= acc_d[i];
                hold_q[i] <= hold_d[i];
            end
        end

        take_rate_a: assert property (@(posedge sys_clk_in)
            disable iff (!rst_n_in)
            take[i] |=> acc_q[i] < $past(acc_q[i]))
            else $error("stream take did not lower accumulator");
    end

    ////////////////////////////////////////////////////////////////////////
    // Output tick, music, mix and routing.
    assign link_on  = (st_q == LNK_RUN);
    assign out_rate = link_on ? `ARML_LINK_RATE
                              : clamp_rate(host_rate_in);
    assign sink_rdy = link_on ? fifo_wr_rdy : host_ready_in;
    assign fire     = pend_q && sink_rdy;
    assign host_valid_out  = pend_q && !link_on;
    assign host_data_out   = mix_q;
    assign music_ready_out = fire;

    // An output sample is owed on every tick until the sink takes it;
    // a stalled sink also stalls the stream accumulators.
    always_comb
    begin
        nco_d  = nco_q + 27'(out_rate);
        pend_d = pend_q && !fire;
        if (nco_d >= `ARML_SYS_CLK_HZ)
        begin
            nco_d  = nco_d - `ARML_SYS_CLK_HZ;
            pend_d = 1'b1;
        end
        // Music lacking at a sample time counts as silence.
        mus_d = fire ? (music_valid_in ? music_data_in : '0) : mus_q;
        mix_d[15:0]  = sat3(hold_q[0][15:0], hold_q[1][15:0],
                            mus_q[15:0]);
        mix_d[31:16] = sat3(hold_q[0][31:16], hold_q[1][31:16],
                            mus_q[31:16]);
    end

    // Registers only.
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            nco_q  <= '0;
            pend_q <= 1'b0;
            mus_q  <= '0;
            mix_q  <= '0;
        end
        else
        begin
            nco_q  <= nco_d;
            pend_q <= pend_d;
            mus_q  <= mus_d;
            mix_q  <= mix_d;
        end
    end

    link_rate_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        link_on |-> out_rate == `ARML_LINK_RATE)
        else $error("link output rate is not 48 kHz");

    host_rate_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        !link_on |-> out_rate >= `ARML_RATE_MIN &&
                     out_rate <= `ARML_RATE_MAX)
        else $error("host output rate out of range");

    route_excl_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (fire && link_on) |-> !host_valid_out)
        else $error("mix offered to host while link runs");

    mix_sum_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        ##1 mix_q[15:0] == sat3($past(hold_q[0][15:0]),
            $past(hold_q[1][15:0]), $past(mus_q[15:0])))
        else $error("left mix is not the saturated sum");

    ////////////////////////////////////////////////////////////////////////
    // Buffer between the mixer and the frame formatter.
    arml_fifo #(
        .WIDTH (32),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_in   (sys_clk_in),
        .rst_n_in     (rst_n_in),
        .wr_valid_in  (pend_q && link_on),
        .wr_ready_out (fifo_wr_rdy),
        .wr_data_in   (mix_q),
        .rd_valid_out (fifo_rd_vld),
        .rd_ready_in  (fifo_pop),
        .rd_data_out  (fifo_rd_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Link control: reset pulse then framing. The reset is held low the
    // whole time the link is off so the codec stays quiet.
    always_comb
    begin
        st_d     = st_q;
        rcnt_d   = rcnt_q;
        unique case (st_q)
            LNK_OFF:
            begin
                if (link_enable_in)
                begin
                    st_d   = LNK_RESET;
                    rcnt_d = 8'(`ARML_RST_LOW_CYC);
                end
            end
            LNK_RESET:
            begin
                rcnt_d = rcnt_q - 8'h01;
                if (rcnt_q == 8'h01)
                begin
                    st_d = LNK_RUN;
                end
            end
            LNK_RUN:
            begin
                if (link_cold_reset_in)
                begin
                    st_d   = LNK_RESET;
                    rcnt_d = 8'(`ARML_RST_LOW_CYC);
                end
            end
            default:
            begin
                st_d = LNK_OFF;
            end
        endcase
        if (!link_enable_in)
        begin
            st_d = LNK_OFF;
        end
        crst_n_d = (st_d == LNK_RUN);
    end

    // Registers only.
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            st_q     <= LNK_OFF;
            rcnt_q   <= '0;
            crst_n_q <= 1'b0;
        end
        else
        begin
            st_q     <= st_d;
            rcnt_q   <= rcnt_d;
            crst_n_q <= crst_n_d;
        end
    end

    assign codec_rst_n_out = crst_n_q;

    // Checking aid: length of the current reset low period.
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in || crst_n_q)
        begin
            rlow_q <= '0;
        end
        else if (rlow_q != 16'hFFFF)
        begin
            rlow_q <= rlow_q + 16'h0001;
        end
    end

    reset_low_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        $rose(codec_rst_n_out) |-> $past(rlow_q) >= `ARML_RST_LOW_CYC - 1)
        else $error("link reset low time too short");

    ////////////////////////////////////////////////////////////////////////
    // Frame formatter: sync and data change on bit clock rising edges;
    // the codec samples them on falling edges.
    assign brise    = bit_clk_in && !bclk_q;
    assign bit_nx   = bit_q + 8'h01;
    assign fifo_pop = link_on && brise && (bit_q == `ARML_FRAME_LAST);

    always_comb
    begin
        bit_d  = bit_q;
        sync_d = sync_q;
        sdo_d  = sdo_q;
        frm_d  = frm_q;
        fv_d   = fv_q;
        if (!link_on)
        begin
            // Sync, data and frame valid low, bit index parked at the frame end, while the codec is held in reset.
            bit_d  = `ARML_FRAME_LAST;
            sync_d = 1'b0;
            sdo_d  = 1'b0;
            fv_d   = 1'b0;
        end
        else if (brise)
        begin
            bit_d  = bit_nx;
            sync_d = (bit_nx < `ARML_SYNC_BITS);
            if (bit_q == `ARML_FRAME_LAST)
            begin
                // An empty buffer sends a frame marked invalid.
                frm_d = fifo_rd_data;
                fv_d  = fifo_rd_vld;
            end
            sdo_d = 1'b0;
            if (bit_nx == `ARML_TAG_FV_POS || bit_nx == `ARML_TAG_S3_POS
                || bit_nx == `ARML_TAG_S4_POS)
            begin
                sdo_d = fv_d;
            end
            else if (bit_nx >= `ARML_SLOT3_START && bit_nx <
                     `ARML_SLOT3_START + `ARML_SLOT_DATA_BITS)
            begin
                sdo_d = fv_d && frm_d[4'(8'h0F - (bit_nx -
                                      `ARML_SLOT3_START))];
            end
            else if (bit_nx >= `ARML_SLOT4_START && bit_nx <
                     `ARML_SLOT4_START + `ARML_SLOT_DATA_BITS)
            begin
                sdo_d = fv_d && frm_d[5'(8'h1F - (bit_nx -
                                      `ARML_SLOT4_START))];
            end
        end
    end

    // Registers only.
    always_ff @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            bclk_q <= 1'b0;
            bit_q  <= `ARML_FRAME_LAST;
            sync_q <= 1'b0;
            sdo_q  <= 1'b0;
            frm_q  <= '0;
            fv_q   <= 1'b0;
        end
        else
        begin
            bclk_q <= bit_clk_in;
            bit_q  <= bit_d;
            sync_q <= sync_d;
            sdo_q  <= sdo_d;
            frm_q  <= frm_d;
            fv_q   <= fv_d;
        end
    end

    assign sync_out  = sync_q;
    assign sdata_out = sdo_q;

    sync_rise_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (link_on && brise && bit_q == `ARML_FRAME_LAST) |=> sync_out)
        else $error("sync not raised at frame start");

    sync_fall_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (link_on && brise && bit_q == `ARML_SYNC_BITS - 1) |=> !sync_out)
        else $error("sync high longer than the tag slot");

    frame_count_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (link_on && brise) |=> bit_q == 8'($past(bit_q) + 8'h01))
        else $error("frame bit index did not advance");

    tag_valid_a: assert property (@(posedge sys_clk_in)
        disable iff (!rst_n_in)
        (link_on && brise && bit_q == `ARML_FRAME_LAST)
            |=> sdata_out == fv_q)
        else $error("tag valid bit wrong");
endmodule // arml_audio_link

// [verif/arml_codec_model.sv]
////////////////////////////////////////////////////////////////////////////
// Behavioural codec at the far end of the serial link.
// It makes the bit clock and captures the frames that the controller sends.
module arml_codec_model (
    input  wire logic         codec_rst_n_in,
    input  wire logic         sync_in,
    input  wire logic         sdata_in,
    output logic              bit_clk_out,
    output int                frame_cnt_out,
    output int                frame_len_out,
    output int                sync_len_out,
    output logic [255:0]      frame_bits_out
);
    timeunit 1ns;
    timeprecision 100ps;

    int          idx;        // Bit index inside the current frame.
    int          scnt;       // Bit periods with sync high in this frame.
    logic        sync_prev;  // Sync level at the previous falling edge.
    logic [255:0] bits;      // Bits of the frame being received.

    initial
    begin
        frame_cnt_out = 0;
        frame_len_out = 0;
        sync_len_out = 0;
        idx = 0;
        scnt = 0;
        sync_prev = 1'b0;
    end

    // The clock stands still low while the link reset is held.
    always
    begin
        // Reset stops the clock low within one bit period.
        bit_clk_out = 1'b0;
        wait (codec_rst_n_in);
        #170;
        while (codec_rst_n_in)
        begin
            #40.7 bit_clk_out = 1'b1;
            #40.7 bit_clk_out = 1'b0;
        end
    end

    // Data is sampled on the falling edge, half a bit after it changes.
    always @(negedge bit_clk_out)
    begin
        if (sync_in && !sync_prev)
        begin
            // A sync rise starts a frame; the previous one is published.
            frame_len_out = idx + 1;
            sync_len_out = scnt;
            frame_bits_out = bits;
            frame_cnt_out++;
            idx = 0;
            scnt = 1;
            bits[0] = sdata_in;
        end
        else
        begin
            idx++;
            if (idx < 256)
                bits[idx] = sdata_in;
            scnt += int'(sync_in);
        end
        sync_prev = sync_in;
    end
endmodule // arml_codec_model

// [verif/tb_audio_resample_mix_link.sv]
////////////////////////////////////////////////////////////////////////////
// Self-checking bench: host path first, then the codec link.
module tb_audio_resample_mix_link
    import arml_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;

    logic sys_clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [1:0] strm_valid_in, strm_ready_out, strm_fmt16_in, strm_stereo_in;
    logic [1:0][31:0] strm_data_in;
    logic [1:0][15:0] strm_rate_in;
    logic music_valid_in, music_ready_out, host_valid_out, host_ready_in;
    logic [31:0] music_data_in, host_data_out;
    logic [15:0] host_rate_in;
    logic link_enable_in, link_cold_reset_in, bit_clk_in;
    logic sync_out, sdata_out, codec_rst_n_out;
    int n_errors = 0;
    int checks = 0;
    int cyc = 0;
    int fcnt, flen, slen;
    logic [255:0] fbits;
    logic host_in_link = 1'b0;  // Host output seen while the link runs.
    // Expected mix: stream 0 plus stream 1 (0x90 -> 0x1000) plus music.
    localparam logic [31:0] MIX = 32'h1210_1120;

    arml_audio_link arml_audio_link_i (.*);
    arml_codec_model arml_codec_model_i (.codec_rst_n_in(codec_rst_n_out),
        .sync_in(sync_out), .sdata_in(sdata_out), .bit_clk_out(bit_clk_in),
        .frame_cnt_out(fcnt), .frame_len_out(flen), .sync_len_out(slen),
        .frame_bits_out(fbits));

    always #5 sys_clk_in = ~sys_clk_in;

    // Cycle count doubles as the hang guard.
    always @(posedge sys_clk_in)
    begin
        cyc++;
        // Only a running link forbids host output; the reset phase is
        // still host mode.
        if (host_valid_out === 1'b1 && codec_rst_n_out === 1'b1)
            host_in_link = 1'b1;
        if (cyc == 95000)
        begin
            n_errors++;
            conclude();
        end
    end

    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("Error %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Waits for one host pulse; the host always takes it at once.
    task automatic wait_host(output int at, output logic [31:0] d);
        while (host_valid_out !== 1'b1)
            @(negedge sys_clk_in);
        at = cyc;
        d = host_data_out;
        check("music ready", 32'(music_ready_out), 1);
        @(negedge sys_clk_in);
    endtask

    // Counts cycles of link reset held low, bounded.
    task automatic rst_low(output int n);
        n = 0;
        while (codec_rst_n_out !== 1'b1 && n < 1000)
        begin
            @(negedge sys_clk_in);
            n++;
        end
    endtask

    task automatic wait_frames(input int k);
        int tgt;
        tgt = fcnt + k;
        while (fcnt < tgt)
            @(negedge sys_clk_in);
    endtask

    // Output rate follows the programmed rate; mix holds all sources.
    task automatic test_host();
        int t0, t1, lo;
        logic [31:0] d;
        int rates [2] = '{48000, 7000};
        // No rate credit has built up yet right after reset.
        check("strm ready", 32'(strm_ready_out), 0);
        for (int k = 0; k < 2; k++)
        begin
            host_rate_in = 16'(rates[k]);
            lo = 100000000 / rates[k];
            // Stream 1 at 8 kHz is first taken on the sixth output tick.
            repeat (k == 0 ? 6 : 2) wait_host(t0, d);
            wait_host(t1, d);
            check("interval", 32'((t1 - t0 - lo) inside {0, 1}), 1);
            check("host mix", d, MIX);
        end
        check("link reset off", 32'(codec_rst_n_out), 0);
        $display("test_host done");
    endtask

    // Link: cold reset length, frame layout and sample contents.
    task automatic test_link();
        int n;
        logic [15:0] l, r;
        link_enable_in = 1'b1;
        rst_low(n);
        check("reset low", 32'(n inside {[100:110]}), 1);
        for (int pass = 0; pass < 2; pass++)
        begin
            wait_frames(5);
            for (int i = 0; i < 16; i++)
            begin
                l[15 - i] = fbits[56 + i];
                r[15 - i] = fbits[76 + i];
            end
            check("frame len", 32'(flen), 256);
            check("sync len", 32'(slen), 16);
            check("tag", 32'({fbits[0], fbits[3], fbits[4]}), 7);
            check("slot", {r, l}, MIX);
            check("host idle", 32'(host_in_link), 0);
            @(negedge sys_clk_in);
            link_cold_reset_in = 1'b1;
            @(negedge sys_clk_in);
            link_cold_reset_in = 1'b0;
            rst_low(n);
            check("cold reset", 32'(n inside {[99:110]}), 1);
        end
        $display("test_link done");
    endtask

    initial
    begin
        strm_valid_in = 2'h3;
        strm_fmt16_in = 2'h1;     // Stream 1 is 8-bit unsigned.
        strm_stereo_in = 2'h1;    // Stream 1 is mono.
        strm_data_in[0] = 32'h0200_0100;
        strm_data_in[1] = 32'h0000_0090;
        strm_rate_in[0] = 16'hBB80;
        strm_rate_in[1] = 16'h1F40;
        music_valid_in = 1'b1;
        music_data_in = 32'h0010_0020;
        host_rate_in = 16'hBB80;
        host_ready_in = 1'b1;
        link_enable_in = 1'b0;
        link_cold_reset_in = 1'b0;
        repeat (12) @(negedge sys_clk_in);
        rst_n_in = 1'b1;
        test_host();
        test_link();
        conclude();
    end
endmodule // tb_audio_resample_mix_link
